// file: core/rcrs_cfg.svh
`ifndef RCRS_CFG_SVH
`define RCRS_CFG_SVH

// Register offsets on the byte-wide host map
`define RCRS_OFF_T4_LOW       7'h1d
`define RCRS_OFF_T4_HIGH      7'h1e
`define RCRS_OFF_T4_UPPER     7'h1f
`define RCRS_OFF_SYN_INT      7'h20
`define RCRS_OFF_SYN_FRAC_LO  7'h21
`define RCRS_OFF_SYN_FRAC_HI  7'h22
`define RCRS_OFF_TX_PWR       7'h23
`define RCRS_OFF_SEQ_VIEW     7'h24
`define RCRS_OFF_LQ           7'h25
`define RCRS_OFF_RSSI         7'h26
`define RCRS_OFF_SEC_CTRL1    7'h28

// Reset values
`define RCRS_RST_T4_BYTE      8'hff
`define RCRS_RST_SYN_INT      5'h18
`define RCRS_RST_FRAC_LO      8'h00
`define RCRS_RST_FRAC_HI      8'h90
`define RCRS_RST_TX_PWR       5'h1f
`define RCRS_RST_SEQ_VIEW     8'h00
`define RCRS_RST_LQ           8'h00
`define RCRS_RST_RSSI         8'h00
`define RCRS_RST_SEC_MODE     4'h0

// Field positions of the first security-engine control register
`define RCRS_SEC_CLEAR_BIT    7
`define RCRS_SEC_START_BIT    6
`define RCRS_SEC_SELF_BIT     5
`define RCRS_SEC_MODE_LSB     2
`define RCRS_SEC_PRELOAD_BIT  1

// Synthesizer word: integer offset added to the 5-bit integer part
`define RCRS_SYN_INT_OFFSET   7'h40

`endif

// file: core/rcrs_pkg.sv
package rcrs_pkg;

`include "rcrs_cfg.svh"

	typedef struct packed
	{
		logic       wr;
		logic       rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} rcrs_reg_req_t;

	typedef struct packed
	{
		logic clear;
		logic start_cipher;
		logic start_selftest;
		logic preload_auth_code;
	} rcrs_sec_cmd_t;

	// Bit order matches register bits 5..2
	typedef struct packed
	{
		logic self_check_mode;
		logic ctr;
		logic cbc;
		logic aes;
	} rcrs_sec_mode_t;

	// Select 0 sequence, 1 receive, 2 transmit, 3 synthesizer manager
	typedef struct packed
	{
		logic [7:0] synth;
		logic [7:0] tx;
		logic [7:0] rx;
		logic [7:0] seq;
	} rcrs_mgr_states_t;

endpackage

// file: core/rcrs_timer4.sv
`timescale 1ns/1ps

module rcrs_timer4
	import rcrs_pkg::*;
#(
	parameter int TIMER_W = 24
)(
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               resetn,
	// Timer control
	input  wire logic               timer_tick,
	input  wire logic               timer4_compare_enable,
	input  wire logic [TIMER_W-1:0] timer4_match_value,
	input  wire logic               timer4_flag_clear,
	// Status
	output logic      [TIMER_W-1:0] event_timer,
	output logic                    timer4_match_flag
);

	logic [TIMER_W-1:0] timer_r;
	logic [TIMER_W-1:0] timer_nxt;
	logic               flag_r;
	logic               flag_nxt;
	logic               hit;

	always_comb
	begin
		hit = timer4_compare_enable && (timer_r == timer4_match_value);
		timer_nxt = timer_tick ? timer_r + 1'b1 : timer_r;
		// Set beats clear so a match in the clearing cycle survives
		flag_nxt = hit ? 1'b1 : (timer4_flag_clear ? 1'b0 : flag_r);
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			timer_r <= '0;
			flag_r  <= 1'b0;
		end
		else
		begin
			timer_r <= timer_nxt;
			flag_r  <= flag_nxt;
		end
	end

	assign event_timer       = timer_r;
	assign timer4_match_flag = flag_r;

	a_match_sets_flag: assert property (@(posedge clk) disable iff (!resetn)
		(timer4_compare_enable && event_timer == timer4_match_value) |=> timer4_match_flag)
		else $error("timer4 match did not set flag");

	a_no_flag_disabled: assert property (@(posedge clk) disable iff (!resetn)
		(!timer4_match_flag && !(timer4_compare_enable
			&& event_timer == timer4_match_value)) |=> !timer4_match_flag)
		else $error("timer4 flag set without match");

endmodule

// file: core/rcrs_regs.sv
// What this block does
// - The timer4 match flag is set when the compare enable is high and the event timer equals the match value.
// - The synthesizer word is integer part plus 64 with the 16-bit fraction below it, in units of 32 MHz over 65536.
// - The synthesizer integer register holds five bits, reads zero in bits 7 to 5 and resets to 0x18.
// - The fraction is split into a low byte resetting to 0x00 and a high byte resetting to 0x90.
// - The output power level is a 5-bit field, linear from 3 to 31, with the upper three bits reserved.
// - The sequencer state view is read-only, resets to zero and shows the manager state picked by a 2-bit select.
// - The link quality register is replaced by the quality figure of each newly received packet.
// - The link quality figure is also appended to the packet buffer right after the received payload.
// - The running signal strength is an average updated on each valid sample, held between samples, and readable during reception.
// - The first security control register at 28h resets to zero and reads 0 in bits 7, 6, 1 and 0.
// - Writing 1 to clear erases engine memory; writing 1 to start runs the cipher mode, or self-check if set.
`timescale 1ns/1ps
`include "rcrs_cfg.svh"

module rcrs_regs
	import rcrs_pkg::*;
#(
	parameter int RSSI_AVG_SHIFT = 2
)(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// Host register port
	input  rcrs_reg_req_t         reg_req,
	output logic [7:0]            reg_rdata,
	output logic                  reg_rvalid,
	// Event timer
	input  wire logic             timer_tick,
	input  wire logic             timer4_compare_enable,
	input  wire logic             timer4_flag_clear,
	output logic                  timer4_match_flag,
	output logic [23:0]           event_timer,
	// Synthesizer and amplifier
	output logic [22:0]           synth_freq_word,
	output logic [4:0]            output_power_level,
	// Sequencer state monitor
	input  wire logic [1:0]       state_view_select,
	input  rcrs_mgr_states_t      mgr_states,
	// Receive quality
	input  wire logic             rx_lq_valid,
	input  wire logic [7:0]       rx_lq_value,
	input  wire logic             rssi_valid,
	input  wire logic [7:0]       rssi_sample,
	output logic                  pb_lq_wr,
	output logic [7:0]            pb_lq_data,
	// Security engine
	output rcrs_sec_cmd_t         sec_cmd,
	output rcrs_sec_mode_t        sec_mode
);

	logic [7:0]     t4_lo_r, t4_lo_nxt;
	logic [7:0]     t4_hi_r, t4_hi_nxt;
	logic [7:0]     t4_up_r, t4_up_nxt;
	logic [4:0]     syn_int_r, syn_int_nxt;
	logic [7:0]     frac_lo_r, frac_lo_nxt;
	logic [7:0]     frac_hi_r, frac_hi_nxt;
	logic [4:0]     pwr_r, pwr_nxt;
	logic [7:0]     view_r, view_nxt;
	logic [7:0]     lq_r, lq_nxt;
	logic [7:0]     rssi_r, rssi_nxt;
	logic           pb_wr_r, pb_wr_nxt;
	logic [7:0]     pb_data_r, pb_data_nxt;
	rcrs_sec_cmd_t  cmd_r, cmd_nxt;
	rcrs_sec_mode_t mode_r, mode_nxt;
	logic [7:0]     rdata_r, rdata_nxt;
	logic           rvalid_r, rvalid_nxt;
	logic [7:0]     rd_mux;
	logic [7:0]     view_sel;
	logic [9:0]     rssi_diff;
	logic [9:0]     rssi_step;
	logic [23:0]    t4_match;

	assign t4_match = {t4_up_r, t4_hi_r, t4_lo_r};

	rcrs_timer4 #(
		.TIMER_W (24)
	) u_timer4 (
		.clk                   (clk),
		.resetn                (resetn),
		.timer_tick            (timer_tick),
		.timer4_compare_enable (timer4_compare_enable),
		.timer4_match_value    (t4_match),
		.timer4_flag_clear     (timer4_flag_clear),
		.event_timer           (event_timer),
		.timer4_match_flag     (timer4_match_flag)
	);

	always_comb
	begin
		unique case (state_view_select)
			2'd0: view_sel = mgr_states.seq;
			2'd1: view_sel = mgr_states.rx;
			2'd2: view_sel = mgr_states.tx;
			2'd3: view_sel = mgr_states.synth;
		endcase
	end

	always_comb
	begin
		unique case (reg_req.addr)
			`RCRS_OFF_T4_LOW:      rd_mux = t4_lo_r;
			`RCRS_OFF_T4_HIGH:     rd_mux = t4_hi_r;
			`RCRS_OFF_T4_UPPER:    rd_mux = t4_up_r;
			`RCRS_OFF_SYN_INT:     rd_mux = {3'h0, syn_int_r};
			`RCRS_OFF_SYN_FRAC_LO: rd_mux = frac_lo_r;
			`RCRS_OFF_SYN_FRAC_HI: rd_mux = frac_hi_r;
			`RCRS_OFF_TX_PWR:      rd_mux = {3'h0, pwr_r};
			`RCRS_OFF_SEQ_VIEW:    rd_mux = view_r;
			`RCRS_OFF_LQ:          rd_mux = lq_r;
			`RCRS_OFF_RSSI:        rd_mux = rssi_r;
			`RCRS_OFF_SEC_CTRL1:   rd_mux = {2'h0, mode_r, 2'h0};
			default:               rd_mux = 8'h00;
		endcase
	end

	always_comb
	begin
		t4_lo_nxt   = t4_lo_r;
		t4_hi_nxt   = t4_hi_r;
		t4_up_nxt   = t4_up_r;
		syn_int_nxt = syn_int_r;
		frac_lo_nxt = frac_lo_r;
		frac_hi_nxt = frac_hi_r;
		pwr_nxt     = pwr_r;
		mode_nxt    = mode_r;
		cmd_nxt     = '0;
		if (reg_req.wr)
		begin
			unique case (reg_req.addr)
				`RCRS_OFF_T4_LOW:      t4_lo_nxt = reg_req.wdata;
				`RCRS_OFF_T4_HIGH:     t4_hi_nxt = reg_req.wdata;
				`RCRS_OFF_T4_UPPER:    t4_up_nxt = reg_req.wdata;
				`RCRS_OFF_SYN_INT:     syn_int_nxt = reg_req.wdata[4:0];
				`RCRS_OFF_SYN_FRAC_LO: frac_lo_nxt = reg_req.wdata;
				`RCRS_OFF_SYN_FRAC_HI: frac_hi_nxt = reg_req.wdata;
				`RCRS_OFF_TX_PWR:      pwr_nxt = reg_req.wdata[4:0];
				`RCRS_OFF_SEC_CTRL1:
				begin
					// Start picks the mode from the same write, so one write can
					// arm self-check and launch it
					mode_nxt = reg_req.wdata[`RCRS_SEC_SELF_BIT:`RCRS_SEC_MODE_LSB];
					cmd_nxt.clear = reg_req.wdata[`RCRS_SEC_CLEAR_BIT];
					cmd_nxt.start_selftest = reg_req.wdata[`RCRS_SEC_START_BIT]
						&& reg_req.wdata[`RCRS_SEC_SELF_BIT];
					cmd_nxt.start_cipher = reg_req.wdata[`RCRS_SEC_START_BIT]
						&& !reg_req.wdata[`RCRS_SEC_SELF_BIT];
					cmd_nxt.preload_auth_code = reg_req.wdata[`RCRS_SEC_PRELOAD_BIT];
				end
				default:
				begin
					// Read-only and unmapped offsets ignore writes
				end
			endcase
		end
	end

	always_comb
	begin
		view_nxt    = view_sel;
		lq_nxt      = rx_lq_valid ? rx_lq_value : lq_r;
		pb_wr_nxt   = rx_lq_valid;
		pb_data_nxt = rx_lq_valid ? rx_lq_value : pb_data_r;
		// Exponential average; arithmetic shift keeps the sign of the step
		rssi_diff   = {2'b00, rssi_sample} - {2'b00, rssi_r};
		rssi_step   = $signed(rssi_diff) >>> RSSI_AVG_SHIFT;
		rssi_nxt    = rssi_valid ? rssi_r + rssi_step[7:0] : rssi_r;
		rdata_nxt   = reg_req.rd ? rd_mux : rdata_r;
		rvalid_nxt  = reg_req.rd;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			t4_lo_r   <= `RCRS_RST_T4_BYTE;
			t4_hi_r   <= `RCRS_RST_T4_BYTE;
			t4_up_r   <= `RCRS_RST_T4_BYTE;
			syn_int_r <= `RCRS_RST_SYN_INT;
			frac_lo_r <= `RCRS_RST_FRAC_LO;
			frac_hi_r <= `RCRS_RST_FRAC_HI;
			pwr_r     <= `RCRS_RST_TX_PWR;
			view_r    <= `RCRS_RST_SEQ_VIEW;
			lq_r      <= `RCRS_RST_LQ;
			rssi_r    <= `RCRS_RST_RSSI;
			pb_wr_r   <= 1'b0;
			pb_data_r <= 8'h00;
			cmd_r     <= '0;
			mode_r    <= `RCRS_RST_SEC_MODE;
			rdata_r   <= 8'h00;
			rvalid_r  <= 1'b0;
		end
		else
		begin
			t4_lo_r   <= t4_lo_nxt;
			t4_hi_r   <= t4_hi_nxt;
			t4_up_r   <= t4_up_nxt;
			syn_int_r <= syn_int_nxt;
			frac_lo_r <= frac_lo_nxt;
			frac_hi_r <= frac_hi_nxt;
			pwr_r     <= pwr_nxt;
			view_r    <= view_nxt;
			lq_r      <= lq_nxt;
			rssi_r    <= rssi_nxt;
			pb_wr_r   <= pb_wr_nxt;
			pb_data_r <= pb_data_nxt;
			cmd_r     <= cmd_nxt;
			mode_r    <= mode_nxt;
			rdata_r   <= rdata_nxt;
			rvalid_r  <= rvalid_nxt;
		end
	end

	// Integer part plus 64 above the fraction; unit is 32 MHz / 65536
	assign synth_freq_word    = {syn_int_r + `RCRS_SYN_INT_OFFSET, frac_hi_r, frac_lo_r};
	assign output_power_level = pwr_r;
	assign pb_lq_wr           = pb_wr_r;
	assign pb_lq_data         = pb_data_r;
	assign sec_cmd            = cmd_r;
	assign sec_mode           = mode_r;
	assign reg_rdata          = rdata_r;
	assign reg_rvalid         = rvalid_r;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sequence s_sec_write(int bitpos);
		reg_req.wr && reg_req.addr == `RCRS_OFF_SEC_CTRL1 && reg_req.wdata[bitpos];
	endsequence

	sequence s_one_pulse_clear;
		sec_cmd.clear ##1 !sec_cmd.clear;
	endsequence

	a_t4_upper_byte: assert property (
		(reg_req.wr && reg_req.addr == `RCRS_OFF_T4_UPPER)
		|=> u_timer4.timer4_match_value[23:16] == $past(reg_req.wdata))
		else $error("timer4 upper byte not in match value");

	a_synth_int_word: assert property (
		(reg_req.wr && reg_req.addr == `RCRS_OFF_SYN_INT)
		|=> synth_freq_word[22:16] == $past(reg_req.wdata[4:0]) + 7'h40)
		else $error("synth integer plus 64 wrong");

	a_int_reserved_zero: assert property (
		(reg_req.rd && reg_req.addr == `RCRS_OFF_SYN_INT) |=> reg_rvalid && reg_rdata[7:5] == 3'h0)
		else $error("synth integer reserved bits not zero");

	a_frac_high_write: assert property (
		(reg_req.wr && reg_req.addr == `RCRS_OFF_SYN_FRAC_HI)
		|=> synth_freq_word[15:8] == $past(reg_req.wdata))
		else $error("fraction high byte not stored");

	a_power_field_write: assert property (
		(reg_req.wr && reg_req.addr == `RCRS_OFF_TX_PWR) |=> output_power_level == $past(reg_req.wdata[4:0]))
		else $error("power level not stored");

	a_view_follows_sel: assert property (
		(reg_req.rd && reg_req.addr == `RCRS_OFF_SEQ_VIEW) |=> reg_rdata == $past(view_r))
		else $error("state view read wrong");

	a_view_tracks_sel: assert property (
		(state_view_select == 2'h3) |=> view_r == $past(mgr_states.synth))
		else $error("state view not following selected manager");

	a_lq_replaced: assert property (
		rx_lq_valid |=> lq_r == $past(rx_lq_value))
		else $error("link quality not updated");

	// Host read two cycles after the packet sees that packet's figure
	a_lq_read_latest: assert property (
		(rx_lq_valid ##1 !rx_lq_valid
			##1 (reg_req.rd && reg_req.addr == `RCRS_OFF_LQ && !rx_lq_valid))
		|=> reg_rdata == $past(rx_lq_value, 3))
		else $error("link quality read not latest packet");

	a_lq_appended: assert property (
		rx_lq_valid |=> pb_lq_wr && pb_lq_data == $past(rx_lq_value))
		else $error("link quality not appended");

	a_rssi_held_idle: assert property (
		!rssi_valid |=> $stable(rssi_r))
		else $error("signal strength moved without sample");

	a_rssi_read_back: assert property (
		(reg_req.rd && reg_req.addr == `RCRS_OFF_RSSI) |=> reg_rvalid && reg_rdata == $past(rssi_r))
		else $error("signal strength read wrong");

	a_sec_readback: assert property (
		(reg_req.rd && reg_req.addr == `RCRS_OFF_SEC_CTRL1)
		|=> reg_rdata[7:6] == 2'h0 && reg_rdata[1:0] == 2'h0)
		else $error("security command bits read nonzero");

	a_clear_one_pulse: assert property (
		// A second clear right behind the first legally extends the pulse
		s_sec_write(`RCRS_SEC_CLEAR_BIT)
		##1 !(reg_req.wr && reg_req.addr == `RCRS_OFF_SEC_CTRL1
			&& reg_req.wdata[`RCRS_SEC_CLEAR_BIT])
		|-> s_one_pulse_clear)
		else $error("clear not a single pulse");

	a_start_selftest: assert property (
		(s_sec_write(`RCRS_SEC_START_BIT) and s_sec_write(`RCRS_SEC_SELF_BIT))
		##1 !(reg_req.wr && reg_req.addr == `RCRS_OFF_SEC_CTRL1
			&& reg_req.wdata[`RCRS_SEC_START_BIT])
		|-> sec_cmd.start_selftest && !sec_cmd.start_cipher ##1 !sec_cmd.start_selftest)
		else $error("start with self-check wrong");

endmodule

// file: verification/rcrs_host_model.sv
`timescale 1ns/1ps

module rcrs_host_model
	import rcrs_pkg::*;
(
	// Clock
	input  wire logic       clk,
	// Register port
	output rcrs_reg_req_t   reg_req,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid
);
	initial reg_req = '0;

	// Strobes last one cycle; fields drop to zero so stale data never lingers
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		reg_req <= '0;
	endtask

	task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
		@(posedge clk);
		reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		reg_req <= '0;
		#1;
		d = reg_rdata;
		v = reg_rvalid;
	endtask
endmodule

// file: verification/rcrs_regs_test.sv
`timescale 1ns/1ps

module rcrs_regs_test
	import rcrs_pkg::*;
;
	logic             clk;
	logic             resetn;
	rcrs_reg_req_t    reg_req;
	logic [7:0]       reg_rdata;
	logic             reg_rvalid;
	logic             tick;
	logic             en;
	logic             clr;
	logic             flag;
	logic [23:0]      event_timer;
	logic [22:0]      synth_freq_word;
	logic [4:0]       power;
	logic [1:0]       sel;
	rcrs_mgr_states_t mgr;
	logic             lqv;
	logic [7:0]       lqval;
	logic             rv;
	logic [7:0]       rs;
	logic             pb_wr;
	logic [7:0]       pb_data;
	rcrs_sec_cmd_t    sec_cmd;
	rcrs_sec_mode_t   sec_mode;
	int               num_errors;
	int               checked;

	rcrs_regs #(.RSSI_AVG_SHIFT(2)) DUT (.clk(clk), .resetn(resetn), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .timer_tick(tick),
		.timer4_compare_enable(en), .timer4_flag_clear(clr), .timer4_match_flag(flag),
		.event_timer(event_timer), .synth_freq_word(synth_freq_word),
		.output_power_level(power), .state_view_select(sel), .mgr_states(mgr),
		.rx_lq_valid(lqv), .rx_lq_value(lqval), .rssi_valid(rv), .rssi_sample(rs),
		.pb_lq_wr(pb_wr), .pb_lq_data(pb_data), .sec_cmd(sec_cmd), .sec_mode(sec_mode));

	rcrs_host_model host (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid));

	always #5 clk = ~clk;

	task automatic summarize();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic rdchk(input logic [6:0] a, input logic [7:0] e, input string n);
		logic [7:0] d;
		logic       v;
		host.rd(a, d, v);
		chk({n, "_rvalid"}, 24'h1, {23'h0, v});
		chk(n, {16'h0, e}, {16'h0, d});
	endtask

	task automatic t_reset();
		rdchk(7'h1d, 8'hff, "t4_low");
		rdchk(7'h1e, 8'hff, "t4_high");
		rdchk(7'h1f, 8'hff, "t4_upper");
		rdchk(7'h20, 8'h18, "syn_int");
		rdchk(7'h21, 8'h00, "frac_lo");
		rdchk(7'h22, 8'h90, "frac_hi");
		rdchk(7'h23, 8'h1f, "power_reg");
		rdchk(7'h24, 8'h00, "view");
		rdchk(7'h25, 8'h00, "link_quality");
		rdchk(7'h26, 8'h00, "rssi_avg");
		rdchk(7'h28, 8'h00, "sec_ctrl");
		rdchk(7'h27, 8'h00, "unmapped");
		chk("synth_word", {1'b0, 23'h589000}, {1'b0, synth_freq_word});
	endtask

	task automatic t_synth();
		host.wr(7'h20, 8'hff);
		host.wr(7'h21, 8'h34);
		host.wr(7'h22, 8'h12);
		#1;
		chk("synth_word", {1'b0, 23'h5f1234}, {1'b0, synth_freq_word});
		rdchk(7'h20, 8'h1f, "syn_int");
		host.wr(7'h23, 8'he3);
		#1;
		chk("power", 24'h3, {19'h0, power});
		rdchk(7'h23, 8'h03, "power_reg");
	endtask

	task automatic t_view();
		mgr <= '{synth: 8'h44, tx: 8'h33, rx: 8'h22, seq: 8'h11};
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			sel <= 2'(i);
			// Read-only: a write must leave the view untouched
			host.wr(7'h24, 8'haa);
			rdchk(7'h24, 8'(8'h11 * (i + 1)), "view");
		end
	endtask

	task automatic t_timer();
		host.wr(7'h1d, 8'h05);
		host.wr(7'h1e, 8'h00);
		host.wr(7'h1f, 8'h00);
		@(posedge clk);
		en <= 1'b1;
		tick <= 1'b1;
		for (int i = 0; i < 40 && flag !== 1'b1; i++)
		begin
			@(posedge clk);
			#1;
		end
		if (flag !== 1'b1)
		begin
			chk("timer4_flag", 24'h1, {23'h0, flag});
			summarize();
		end
		chk("timer_at_flag", 24'h6, event_timer);
		tick <= 1'b0;
		en <= 1'b0;
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		#1;
		chk("flag_cleared", 24'h0, {23'h0, flag});
	endtask

	task automatic t_rx();
		logic [7:0] lq [3] = '{8'h5a, 8'h3c, 8'h77};
		logic [7:0] sm [3] = '{8'h40, 8'h40, 8'h00};
		// Last sample lies below the average, so the step is negative
		logic [7:0] av [3] = '{8'h10, 8'h1c, 8'h15};
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk);
			lqval <= lq[i];
			lqv <= 1'b1;
			rs <= sm[i];
			rv <= 1'b1;
			@(posedge clk);
			lqv <= 1'b0;
			rv <= 1'b0;
			#1;
			chk("pb_wr", 24'h1, {23'h0, pb_wr});
			chk("pb_data", {16'h0, lq[i]}, {16'h0, pb_data});
			rdchk(7'h25, lq[i], "link_quality");
			rdchk(7'h26, av[i], "rssi_avg");
		end
	endtask

	task automatic t_sec();
		logic [7:0] wd [3] = '{8'hff, 8'h48, 8'h00};
		logic [3:0] ec [3] = '{4'b1011, 4'b0100, 4'b0000};
		logic [3:0] em [3] = '{4'hf, 4'h2, 4'h0};
		for (int i = 0; i < 3; i++)
		begin
			host.wr(7'h28, wd[i]);
			#1;
			chk("sec_cmd", {20'h0, ec[i]}, {20'h0, sec_cmd});
			chk("sec_mode", {20'h0, em[i]}, {20'h0, sec_mode});
			@(posedge clk);
			#1;
			chk("sec_cmd_end", 24'h0, {20'h0, sec_cmd});
			rdchk(7'h28, {2'b00, em[i], 2'b00}, "sec_ctrl");
		end
	endtask

	initial
	begin
		clk = 1'b0;
		resetn = 1'b0;
		{tick, en, clr, sel, lqv, lqval, rv, rs} = '0;
		mgr = '0;
		num_errors = 0;
		checked = 0;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_synth();
		t_view();
		t_timer();
		t_rx();
		t_sec();
		summarize();
	end
endmodule
